// ===== rtl/pft_fault_trigger_unit.sv
`timescale 1ns/10ps
// Notes on behaviour
// (RL1) Four independent generators, selected by index
// (RL2) Per-input polarity for four external faults
// (RL3) Fault is OR of enabled, sensed sources
// (RL4) Group zero external, group one comparators
// (RL5) Trigger enables read back as written
// (RL6) Legacy mode uses input zero only
// (RL7) Status: one bit per trigger
// (RL8) Latched mode reports latched state
// (RL9) Latched bits stay until software clears
// (RL10) Minimum fault period stretches fault
// (RL11) Write one clears event bit
// (RL12) Six event bits per generator
// (RL13) Interrupt needs module and source enable
// (RL14) Fault interrupt is OR of triggers
// (RL15) Fault interrupt held while stretched
// (RL16) Suppressed outputs driven low on fault
// (RL17) Assertion beats clear in same cycle
// (RL18) Counter reloads on assertion, counts down
module pft_fault_trigger_unit
  import pft_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [NUM_EXT-1:0] extFaultInput,
  input wire logic [NUM_GEN*NUM_CMP-1:0] cmpTrigger,
  input wire logic [NUM_GEN*NUM_EVT-1:0] genEvent,
  input wire logic [NUM_GEN*2-1:0] pwmIn,
  input wire logic [NUM_GEN*2-1:0] faultSuppress,
  input wire logic [GEN_IDX_W-1:0] genSel,
  input wire logic groupSel,
  input wire logic cfgWe,
  input wire logic latchedFaultMode,
  input wire logic minFaultPeriodMode,
  input wire logic extendedSourceSelectMode,
  input wire logic senseWe,
  input wire logic [NUM_EXT-1:0] inputActiveHigh,
  input wire logic [MINPER_W-1:0] minPeriod,
  input wire logic trigWe,
  input wire logic [GROUP_W-1:0] trigData,
  input wire logic faultClrWe,
  input wire logic [GROUP_W-1:0] faultClrMask,
  input wire logic evtEnWe,
  input wire logic [NUM_EVT-1:0] evtEnData,
  input wire logic evtClrWe,
  input wire logic [NUM_EVT-1:0] evtClrMask,
  input wire logic [NUM_GEN-1:0] genIntEnable,
  output logic [GROUP_W-1:0] trigReadback,
  output logic [GROUP_W-1:0] faultStatus,
  output logic [NUM_EVT-1:0] evtStatus,
  output logic [NUM_GEN-1:0] faultInt,
  output logic [NUM_GEN-1:0] genInt,
  output logic [NUM_GEN*2-1:0] pwmOut
);
  logic [NUM_GEN-1:0] latched_r;
  logic [NUM_GEN-1:0] minPer_r;
  logic [NUM_GEN-1:0] extSrc_r;
  logic [NUM_EXT-1:0] sense_r [NUM_GEN];
  logic [MINPER_W-1:0] minPeriod_r [NUM_GEN];
  logic [NUM_EXT-1:0] extEn_r [NUM_GEN];
  logic [NUM_CMP-1:0] cmpEn_r [NUM_GEN];
  logic [NUM_EVT-1:0] evtEn_r [NUM_GEN];
  logic [NUM_EXT-1:0] extStat [NUM_GEN];
  logic [NUM_CMP-1:0] cmpStat [NUM_GEN];
  logic [NUM_EVT-1:0] evtStat [NUM_GEN];
  logic [NUM_GEN-1:0] fault;
  logic [NUM_GEN-1:0] genHit;
  logic selExt;
  logic selCmp;
  logic [GROUP_W-1:0] trigSel;
  logic [GROUP_W-1:0] statSel;

  // One-hot decode shared by the fault-clear and event-clear strobes
  always_comb begin
    genHit = MODE_RST;
    genHit[genSel] = 1'b1;
  end
  assign selExt = (groupSel == GROUP_EXT);
  assign selCmp = (groupSel == GROUP_CMP);

  // (RL1) per-generator mode bits
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      latched_r <= MODE_RST;
      minPer_r <= MODE_RST;
      extSrc_r <= MODE_RST;
    end else if (cfgWe) begin
      latched_r[genSel] <= latchedFaultMode;
      minPer_r[genSel] <= minFaultPeriodMode;
      extSrc_r[genSel] <= extendedSourceSelectMode;
    end
  end

  // (RL2) sense per generator
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int g = 0; g < NUM_GEN; g++) begin
        sense_r[g] <= SENSE_RST;
      end
    end else if (senseWe) begin
      sense_r[genSel] <= inputActiveHigh;
    end
  end

  // (RL10) minimum period per generator
  // Shares the sense strobe, so both must be written together
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int g = 0; g < NUM_GEN; g++) begin
        minPeriod_r[g] <= MINPER_RST;
      end
    end else if (senseWe) begin
      minPeriod_r[genSel] <= minPeriod;
    end
  end

  // (RL4) external group enables
  // Group zero has four sources; upper write bits are dropped
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int g = 0; g < NUM_GEN; g++) begin
        extEn_r[g] <= EXT_EN_RST;
      end
    end else if (trigWe && selExt) begin
      extEn_r[genSel] <= trigData[NUM_EXT-1:0];
    end
  end

  // (RL4) comparator group enables
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int g = 0; g < NUM_GEN; g++) begin
        cmpEn_r[g] <= CMP_EN_RST;
      end
    end else if (trigWe && selCmp) begin
      cmpEn_r[genSel] <= trigData;
    end
  end

  // (RL13) per-source event enables
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int g = 0; g < NUM_GEN; g++) begin
        evtEn_r[g] <= EVT_EN_RST;
      end
    end else if (evtEnWe) begin
      evtEn_r[genSel] <= evtEnData;
    end
  end

  // (RL5) enables of selected group
  always_comb begin
    trigSel = cmpEn_r[genSel];
    if (selExt) begin
      trigSel = {EXT_PAD, extEn_r[genSel]};
    end
  end

  // (RL7) status of selected group
  always_comb begin
    statSel = cmpStat[genSel];
    if (selExt) begin
      statSel = {EXT_PAD, extStat[genSel]};
    end
  end

  // (RL5) enables read back as written
  // Registered: costs a cycle, but software never sees a mux glitch
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      trigReadback <= GROUP_RST;
    end else begin
      trigReadback <= trigSel;
    end
  end

  // (RL7) fault status register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      faultStatus <= GROUP_RST;
    end else begin
      faultStatus <= statSel;
    end
  end

  // (RL12) event status register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      evtStatus <= EVT_RST;
    end else begin
      evtStatus <= evtStat[genSel];
    end
  end

  for (genvar g = 0; g < NUM_GEN; g++) begin : gen_slice
    pft_gen_slice u_slice (
      .clock(clock),
      .rst_n(rst_n),
      .extFaultInput(extFaultInput),
      .cmpTrigger(cmpTrigger[g*NUM_CMP +: NUM_CMP]),
      .latchedFaultMode(latched_r[g]),
      .minFaultPeriodMode(minPer_r[g]),
      .extendedSourceSelectMode(extSrc_r[g]),
      .inputActiveHigh(sense_r[g]),
      .extEnable(extEn_r[g]),
      .cmpEnable(cmpEn_r[g]),
      .minPeriod(minPeriod_r[g]),
      .clrExtWe(faultClrWe && genHit[g] && selExt),
      .clrCmpWe(faultClrWe && genHit[g] && selCmp),
      .clrMask(faultClrMask),
      .evtIn(genEvent[g*NUM_EVT +: NUM_EVT]),
      .evtEnable(evtEn_r[g]),
      .evtClrWe(evtClrWe && genHit[g]),
      .evtClrMask(evtClrMask),
      .genIntEnable(genIntEnable[g]),
      .extStatus(extStat[g]),
      .cmpStatus(cmpStat[g]),
      .fault(fault[g]),
      .evtStatus(evtStat[g]),
      .genInt(genInt[g])
    );
  end

  // (RL14) fault interrupt from combined triggers
  assign faultInt = fault;

  // (RL16) suppressed outputs forced low
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pwmOut <= OUT_RST;
    end else begin
      for (int i = 0; i < NUM_GEN*2; i++) begin
        pwmOut[i] <= (fault[i/2] && faultSuppress[i]) ? FAULT_OUT_LEVEL : pwmIn[i];
      end
    end
  end
endmodule // pft_fault_trigger_unit

// ===== rtl/pft_pkg.sv
package pft_pkg;
  localparam int NUM_GEN = 4;
  localparam int GEN_IDX_W = 2;
  localparam int NUM_EXT = 4;
  localparam int NUM_CMP = 8;
  localparam int NUM_EVT = 6;
  localparam int MINPER_W = 16;
  localparam int GROUP_W = 8;
  // Event-status bit positions
  localparam int EVT_ZERO = 0;
  localparam int EVT_LOAD = 1;
  localparam int EVT_A_UP = 2;
  localparam int EVT_A_DN = 3;
  localparam int EVT_B_UP = 4;
  localparam int EVT_B_DN = 5;
  // Reset values
  localparam logic [NUM_EXT-1:0] SENSE_RST = 4'h0;
  localparam logic [NUM_EXT-1:0] EXT_EN_RST = 4'h0;
  localparam logic [NUM_CMP-1:0] CMP_EN_RST = 8'h00;
  localparam logic [MINPER_W-1:0] MINPER_RST = 16'h0000;
  localparam logic [NUM_EVT-1:0] EVT_RST = 6'h00;
  localparam logic [NUM_EVT-1:0] EVT_EN_RST = 6'h00;
  localparam logic [NUM_EXT-1:0] EXT_ZERO_ONLY = 4'h1;
  localparam logic [NUM_EXT-1:0] EXT_NONE = 4'h0;
  localparam logic [NUM_CMP-1:0] CMP_NONE = 8'h00;
  localparam logic [NUM_GEN-1:0] MODE_RST = 4'h0;
  localparam logic [GROUP_W-1:0] GROUP_RST = 8'h00;
  localparam logic [GROUP_W-NUM_EXT-1:0] EXT_PAD = 4'h0;
  localparam logic [NUM_GEN*2-1:0] OUT_RST = 8'h00;
  localparam logic [MINPER_W-1:0] MINPER_STEP = 16'h0001;
  // Fault groups
  localparam logic GROUP_EXT = 1'b0;
  localparam logic GROUP_CMP = 1'b1;
  // Output level while suppressed by a fault
  localparam logic FAULT_OUT_LEVEL = 1'b0;
  typedef enum logic {MP_IDLE, MP_HOLD} pft_minper_e;
endpackage

// ===== rtl/pft_gen_slice.sv
`timescale 1ns/10ps
module pft_gen_slice
  import pft_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [NUM_EXT-1:0] extFaultInput,
  input wire logic [NUM_CMP-1:0] cmpTrigger,
  input wire logic latchedFaultMode,
  input wire logic minFaultPeriodMode,
  input wire logic extendedSourceSelectMode,
  input wire logic [NUM_EXT-1:0] inputActiveHigh,
  input wire logic [NUM_EXT-1:0] extEnable,
  input wire logic [NUM_CMP-1:0] cmpEnable,
  input wire logic [MINPER_W-1:0] minPeriod,
  input wire logic clrExtWe,
  input wire logic clrCmpWe,
  input wire logic [GROUP_W-1:0] clrMask,
  input wire logic [NUM_EVT-1:0] evtIn,
  input wire logic [NUM_EVT-1:0] evtEnable,
  input wire logic evtClrWe,
  input wire logic [NUM_EVT-1:0] evtClrMask,
  input wire logic genIntEnable,
  output logic [NUM_EXT-1:0] extStatus,
  output logic [NUM_CMP-1:0] cmpStatus,
  output logic fault,
  output logic [NUM_EVT-1:0] evtStatus,
  output logic genInt
);
  logic [NUM_EXT-1:0] extAsserted;
  logic [NUM_EXT-1:0] extSel;
  logic [NUM_EXT-1:0] extLatch_r;
  logic [NUM_CMP-1:0] cmpLatch_r;
  logic [NUM_EXT-1:0] extView;
  logic [NUM_CMP-1:0] cmpView;
  logic rawFault;
  logic rawFaultD_r;
  logic [MINPER_W-1:0] mpCount_r;
  pft_minper_e mpState_r;
  logic [NUM_EVT-1:0] evt_r;

  // (RL2) per-input polarity
  assign extAsserted = ~(extFaultInput ^ inputActiveHigh);
  // (RL6) legacy uses input zero only
  assign extSel = extendedSourceSelectMode ? extEnable : EXT_ZERO_ONLY;

  // (RL9) latch until masked clear
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      extLatch_r <= EXT_NONE;
      cmpLatch_r <= CMP_NONE;
    end else begin
      // (RL17) new assertion beats clear
      extLatch_r <= (extLatch_r & ~(clrExtWe ? clrMask[NUM_EXT-1:0] : EXT_NONE)) | extAsserted;
      cmpLatch_r <= (cmpLatch_r & ~(clrCmpWe ? clrMask : CMP_NONE)) | cmpTrigger;
    end
  end

  // (RL8) latched or live view
  assign extView = latchedFaultMode ? extLatch_r : extAsserted;
  assign cmpView = latchedFaultMode ? cmpLatch_r : cmpTrigger;
  // (RL7) one bit per trigger
  assign extStatus = extView;
  assign cmpStatus = cmpView;

  // (RL3) OR of enabled sources
  assign rawFault = |(extView & extSel) | (extendedSourceSelectMode & |(cmpView & cmpEnable));

  // (RL18) reload on new assertion
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rawFaultD_r <= 1'b0;
      mpCount_r <= MINPER_RST;
      mpState_r <= MP_IDLE;
    end else begin
      rawFaultD_r <= rawFault;
      case (mpState_r)
        MP_IDLE: begin
          if (rawFault && !rawFaultD_r && minFaultPeriodMode && minPeriod != MINPER_RST) begin
            mpCount_r <= minPeriod - MINPER_STEP;
            mpState_r <= MP_HOLD;
          end
        end
        MP_HOLD: begin
          if (rawFault && !rawFaultD_r) begin
            mpCount_r <= minPeriod - MINPER_STEP;
          end else if (mpCount_r == MINPER_RST || !minFaultPeriodMode) begin
            mpState_r <= MP_IDLE;
          end else begin
            mpCount_r <= mpCount_r - MINPER_STEP;
          end
        end
        default: mpState_r <= MP_IDLE;
      endcase
    end
  end

  // (RL10) stretch while counting; (RL15) interrupt follows
  assign fault = rawFault | (mpState_r == MP_HOLD);

  // (RL11) write-one clear, set wins
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      evt_r <= EVT_RST;
    end else begin
      evt_r <= (evt_r & ~(evtClrWe ? evtClrMask : EVT_RST)) | evtIn;
    end
  end
  // (RL12) six event bits
  assign evtStatus = evt_r;
  // (RL13) both enables needed
  assign genInt = genIntEnable & |(evt_r & evtEnable);
endmodule // pft_gen_slice

// ===== verif/pft_fault_src_model.sv
`timescale 1ns/10ps
module pft_fault_src_model
  import pft_pkg::*;
(
  input logic clock,
  input logic [NUM_EXT-1:0] extReq,
  input logic [NUM_GEN*NUM_CMP-1:0] cmpReq,
  output logic [NUM_EXT-1:0] extFaultInput = '0,
  output logic [NUM_GEN*NUM_CMP-1:0] cmpTrigger = '0
);
  // Pins move just after an edge, as a real source would
  always @(posedge clock) begin
    extFaultInput <= extReq;
    cmpTrigger <= cmpReq;
  end
endmodule // pft_fault_src_model

// ===== verif/pft_fault_trigger_unit_properties.sv
`timescale 1ns/10ps
module pft_fault_trigger_unit_properties
  import pft_pkg::*;
(
  input logic clock,
  input logic rst_n,
  input logic [NUM_EXT-1:0] extFaultInput,
  input logic [NUM_GEN*NUM_EVT-1:0] genEvent,
  input logic [NUM_GEN*2-1:0] pwmIn,
  input logic [NUM_GEN*2-1:0] faultSuppress,
  input logic [GEN_IDX_W-1:0] genSel,
  input logic groupSel,
  input logic trigWe,
  input logic [GROUP_W-1:0] trigData,
  input logic evtClrWe,
  input logic [NUM_EVT-1:0] evtClrMask,
  input logic [NUM_GEN-1:0] genIntEnable,
  input logic [GROUP_W-1:0] trigReadback,
  input logic [GROUP_W-1:0] faultStatus,
  input logic [NUM_EVT-1:0] evtStatus,
  input logic [NUM_GEN-1:0] faultInt,
  input logic [NUM_GEN-1:0] genInt,
  input logic [NUM_GEN*2-1:0] pwmOut
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [7:0] faultPair;
  assign faultPair = {{2{faultInt[3]}}, {2{faultInt[2]}}, {2{faultInt[1]}}, {2{faultInt[0]}}};
  // Selection held a cycle after the write, so the readback shows it
  sequence trigWrite;
    trigWe ##1 ($stable(genSel) && $stable(groupSel) && !trigWe);
  endsequence
  sequence evtClear;
    evtClrWe && genEvent == 0 ##1 ($stable(genSel) && genEvent == 0 && !evtClrWe);
  endsequence
  chk_trig_readback: assert property (trigWrite |=>
    trigReadback == ($past(trigData, 2) & ($past(groupSel) ? 8'hFF : 8'h0F)))
    else $error("trigger enable readback wrong");
  chk_group_upper: assert property (!groupSel |=> trigReadback[7:4] == 4'h0)
    else $error("group zero readback upper bits set");
  chk_status_upper: assert property (!groupSel |=> faultStatus[7:4] == 4'h0)
    else $error("group zero status upper bits set");
  chk_evt_clear: assert property (evtClear |=> (evtStatus & $past(evtClrMask, 2)) == 6'h00)
    else $error("event bit survived clear");
  chk_int_enable: assert property ((genInt & ~genIntEnable) == 4'h0)
    else $error("generator interrupt without module enable");
  chk_pwm_suppress: assert property (1'b1 |=>
    pwmOut == ($past(pwmIn) & ~($past(faultSuppress) & $past(faultPair))))
    else $error("output suppression wrong");
  chk_reset_clear: assert property ($rose(rst_n) |-> evtStatus == 6'h00 && genInt == 4'h0)
    else $error("event state not clear after reset");
  chk_legacy_default: assert property (
    $rose(rst_n) && $stable(extFaultInput) |-> faultInt == {4{~extFaultInput[0]}})
    else $error("legacy fault source wrong after reset");
endmodule // pft_fault_trigger_unit_properties

// ===== verif/tb_pwm_fault_trigger_unit.sv
`timescale 1ns/10ps
module tb_pwm_fault_trigger_unit import pft_pkg::*;;
  logic clock = 0, rst_n = 0, groupSel = 0, cfgWe = 0, senseWe = 0, trigWe = 0;
  logic latchedFaultMode = 0, minFaultPeriodMode = 0, extendedSourceSelectMode = 0;
  logic faultClrWe = 0, evtEnWe = 0, evtClrWe = 0;
  logic [31:0] cmpReq = '0, cmpTrigger;
  logic [23:0] genEvent = '0;
  logic [7:0] pwmIn = '0, faultSuppress = '0, trigData = '0, faultClrMask = '0, d;
  logic [7:0] trigReadback, faultStatus, pwmOut;
  logic [5:0] evtEnData = '0, evtClrMask = '0, evtStatus;
  logic [3:0] extReq = '0, inputActiveHigh = '0, genIntEnable = '0, extFaultInput;
  logic [3:0] faultInt, genInt, e, sns[4], ens[4];
  logic [1:0] genSel = '0;
  logic [15:0] minPeriod = '0;
  int bad_count = 0, tests_run = 0, cycles = 0, seed = 32'he51e, cnt;
  pft_fault_src_model src (.clock, .extReq, .cmpReq, .extFaultInput, .cmpTrigger);
  pft_fault_trigger_unit dut (.clock, .rst_n, .extFaultInput, .cmpTrigger, .genEvent, .pwmIn,
    .faultSuppress, .genSel, .groupSel, .cfgWe, .latchedFaultMode, .minFaultPeriodMode,
    .extendedSourceSelectMode, .senseWe, .inputActiveHigh, .minPeriod, .trigWe, .trigData,
    .faultClrWe, .faultClrMask, .evtEnWe, .evtEnData, .evtClrWe, .evtClrMask, .genIntEnable,
    .trigReadback, .faultStatus, .evtStatus, .faultInt, .genInt, .pwmOut);
  initial forever #12.5 clock = ~clock;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic look(input logic [1:0] g, input logic p);
    @(posedge clock);
    genSel <= g;
    groupSel <= p;
    repeat (2) @(posedge clock);
    #1;
  endtask
  // Config, sense and group zero enables in one cycle, group one the next
  task automatic setup(input logic [1:0] g, input logic [2:0] m, input logic [3:0] s,
                       input logic [15:0] per, input logic [3:0] en0, input logic [7:0] en1);
    @(posedge clock);
    {genSel, latchedFaultMode, minFaultPeriodMode, extendedSourceSelectMode} <= {g, m};
    {inputActiveHigh, minPeriod, trigData} <= {s, per, 4'h0, en0};
    {cfgWe, senseWe, trigWe, groupSel} <= 4'hE;
    @(posedge clock);
    {cfgWe, senseWe, groupSel, trigData} <= {3'b001, en1};
    @(posedge clock);
    trigWe <= 1'b0;
  endtask
  function automatic logic [3:0] expF(input logic [3:0] v);
    for (int g = 0; g < 4; g++) expF[g] = |((v ~^ sns[g]) & ens[g]);
  endfunction
  always @(posedge clock) begin
    cycles <= cycles + 1;
    pwmIn <= 8'($random(seed));
    faultSuppress <= 8'($random(seed));
    if (cycles == 2000) begin
      bad_count++;
      finish_test();
    end
  end
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    extReq <= 4'h1;
    setup(0, 3'b000, 4'h0, 16'h0, 4'hF, 8'h00);
    #1 chk({4'h0, faultInt}, 8'h00);
    $display("legacy source test done");
    for (int g = 0; g < 4; g++) begin
      {sns[g], ens[g], d} = 16'($random(seed));
      setup(2'(g), 3'b001, sns[g], 16'h0, ens[g], d);
      look(2'(g), 0);
      chk(trigReadback, {4'h0, ens[g]});
      look(2'(g), 1);
      chk(trigReadback, d);
    end
    repeat (8) begin
      e = 4'($random(seed));
      @(posedge clock) extReq <= e;
      repeat (3) @(posedge clock);
      #1 chk({4'h0, faultInt}, {4'h0, expF(e)});
    end
    $display("sense and enable test done");
    extReq <= 4'h0;
    setup(0, 3'b101, 4'hF, 16'h0, 4'h0, 8'h01);
    cmpReq <= 32'h1;
    @(posedge clock) cmpReq <= 32'h0;
    look(0, 1);
    chk(faultStatus, 8'h01);
    cmpReq <= 32'h1;
    repeat (2) @(posedge clock);
    {faultClrWe, faultClrMask} <= 9'h101;
    cmpReq <= 32'h0;
    @(posedge clock) faultClrWe <= 1'b0;
    look(0, 1);
    chk(faultStatus, 8'h01);
    @(posedge clock) faultClrWe <= 1'b1;
    @(posedge clock) faultClrWe <= 1'b0;
    look(0, 1);
    chk(faultStatus, 8'h00);
    $display("latched test done");
    setup(1, 3'b011, 4'hF, 16'd5, 4'h2, 8'h00);
    extReq <= 4'h2;
    @(posedge clock) extReq <= 4'h0;
    cnt = 0;
    repeat (20) @(posedge clock) #1 cnt += faultInt[1];
    chk({7'h0, cnt >= 5 && cnt < 20}, 8'h01);
    $display("minimum period test done");
    @(posedge clock);
    {genSel, evtEnWe, evtEnData, genIntEnable, genEvent} <= {2'd2, 7'h41, 4'h4, 24'h03F000};
    @(posedge clock) {evtEnWe, genEvent} <= '0;
    look(2, 0);
    chk({2'b0, evtStatus}, 8'h3F);
    chk({4'h0, genInt}, 8'h04);
    @(posedge clock) {evtClrWe, evtClrMask} <= 7'h55;
    @(posedge clock) evtClrWe <= 1'b0;
    look(2, 0);
    chk({2'b0, evtStatus}, 8'h2A);
    chk({4'h0, genInt}, 8'h00);
    $display("event test done");
    finish_test();
  end
endmodule // tb_pwm_fault_trigger_unit
bind pft_fault_trigger_unit pft_fault_trigger_unit_properties chk (.clock, .rst_n, .extFaultInput,
  .genEvent, .pwmIn, .faultSuppress, .genSel, .groupSel, .trigWe, .trigData, .evtClrWe,
  .evtClrMask, .genIntEnable, .trigReadback, .faultStatus, .evtStatus, .faultInt, .genInt, .pwmOut);
